// ---- design/reset_cause_defs.vh ----
// register map, field positions, reset values and vectors of the reset-cause block
`ifndef RESET_CAUSE_DEFS_VH
`define RESET_CAUSE_DEFS_VH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define OFF_CTRL        8'h00
`define OFF_STAT        8'h04
`define OFF_CFG         8'h08

// -----------------------------------------------------------------
// reset_control_reg field positions
// -----------------------------------------------------------------
`define BIT_POR         0
`define BIT_BOR         1
`define BIT_IDLE        2
`define BIT_SLEEP       3
`define BIT_WATCHDOG_TIMEOUT_FLAG        4
`define BIT_SOFTWARE_WATCHDOG_ENABLE      5
`define BIT_SWR         6
`define BIT_EXTERNAL_RESET_FLAG        7
`define LOW_VOLTAGE_LEVEL_LO         8
`define LOW_VOLTAGE_LEVEL_HI         11
`define BIT_LOW_VOLTAGE_DETECT_ENABLE       12
`define BIT_REFST       13
`define BIT_IOP         14
`define BIT_TRAP        15

// -----------------------------------------------------------------
// reset values and masks
// -----------------------------------------------------------------
`define CTRL_POR_VAL    16'h0003
`define CTRL_WMASK      16'hdfff
`define CFG_ERASED      1'b1
`define ZERO16          16'h0000

// -----------------------------------------------------------------
// restart addresses
// -----------------------------------------------------------------
`define VEC_RESET       24'h000000
`define VEC_CLKFAIL     24'h000004
`define PC_STEP         24'h000002

// -----------------------------------------------------------------
// power-save parameter and watchdog defaults
// -----------------------------------------------------------------
`define PSAV_IDLE       1'b1
`define WDT_WIDTH_DEF   16
`define WDT_TIMEOUT_DEF 16'h0400

`endif

// ---- design/reset_cause_watchdog_lvd_ctrl.v ----
// reset-cause flags, restart vector selection, watchdog, low-voltage-detect and power-save control
`timescale 1ns/1ns
`include "reset_cause_defs.vh"

module reset_cause_watchdog_lvd_ctrl #(
	parameter                 WDT_WIDTH   = `WDT_WIDTH_DEF,
	parameter [WDT_WIDTH-1:0] WDT_TIMEOUT = `WDT_TIMEOUT_DEF
) (
	// clock and reset (reset is the power-on event)
	input  wire        clk,
	input  wire        reset,
	// register port
	input  wire [7:0]  regAddr,
	input  wire [15:0] regWdata,
	input  wire        regWrite,
	input  wire        regRead,
	output reg  [15:0] regRdata,
	// reset and trap events from sensors and core, one-cycle pulses
	input  wire        brownOutEvent,
	input  wire        softwareResetInstr,
	input  wire        trapLockupEvent,
	input  wire        illegalOpEvent,
	input  wire        clockFailEvent,
	// master reset pin, input only
	input  wire        masterResetPinN,
	// power save and wake
	input  wire        powerSaveInstr,
	input  wire [7:0]  powerSaveParam,
	input  wire        interruptWake,
	input  wire [23:0] interruptVector,
	input  wire [23:0] currentPc,
	// watchdog
	input  wire        wdtRcClk,
	input  wire        clearWatchdogInstr,
	// low-voltage detector analog side
	input  wire        referenceStableIn,
	input  wire        supplyBelowLevel,
	// outputs to core
	output reg         coreReset,
	output reg         restartLoad,
	output reg  [23:0] restartPc,
	output reg  [1:0]  powerState,
	output reg         watchdogTimeout,
	// outputs to low-voltage detector
	output wire [3:0]  lowVoltageLevel,
	output wire        lowVoltageEnable,
	output reg         lowVoltageEvent
);

	// -----------------------------------------------------------------
	// states
	// -----------------------------------------------------------------
	localparam [1:0] ST_RUN   = 2'h0;
	localparam [1:0] ST_SLEEP = 2'h1;
	localparam [1:0] ST_IDLE  = 2'h2;

	// -----------------------------------------------------------------
	// storage
	// -----------------------------------------------------------------
	reg [15:0]          ctrl_reg;
	reg [15:0]          ctrl_next;
	reg                 cfgEnable_reg;
	reg [1:0]           state_reg;
	reg [1:0]           state_next;
	reg [WDT_WIDTH-1:0] wdtCount_reg;
	reg [WDT_WIDTH-1:0] wdtCount_next;
	reg                 rcSync1_reg;
	reg                 rcSync2_reg;
	reg                 rcSync3_reg;
	reg                 pinPrev_reg;
	reg                 refStable_reg;

	// per-event working values
	reg [15:0]          evSet;
	reg [15:0]          evClr;
	reg                 evReset;
	reg                 evLoad;
	reg [23:0]          evPc;
	reg                 evWake;
	reg [15:0]          ctrlBase;

	wire                rcTick;
	wire                pinFall;
	wire                wdtEnabled;
	wire                wdtExpire;

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	// clear first, then set, so a set always wins over a clear
	function [15:0] setClr;
		input [15:0] val;
		input [15:0] setMask;
		input [15:0] clrMask;
		begin
			setClr = (val & ~clrMask) | setMask;
		end
	endfunction

	function [15:0] bitMask;
		input integer pos;
		begin
			bitMask = `ZERO16;
			bitMask[pos] = 1'b1;
		end
	endfunction

	// -----------------------------------------------------------------
	// RC oscillator tick and pin edge
	// -----------------------------------------------------------------
	// the RC clock is sampled, so the watchdog stops if clk dies;
	// a true failing-clock watchdog would move this counter to wdtRcClk
	assign rcTick     = rcSync2_reg & ~rcSync3_reg;
	// pin is only sensed; no output driver exists for it
	assign pinFall    = pinPrev_reg & ~masterResetPinN;
	assign wdtEnabled = cfgEnable_reg | ctrl_reg[`BIT_SOFTWARE_WATCHDOG_ENABLE];
	assign wdtExpire  = wdtEnabled & rcTick & (wdtCount_reg == WDT_TIMEOUT);

	// -----------------------------------------------------------------
	// event decode, highest priority first
	// -----------------------------------------------------------------
	always @* begin
		evSet   = `ZERO16;
		evClr   = `ZERO16;
		evReset = 1'b0;
		evLoad  = 1'b0;
		evPc    = `VEC_RESET;
		evWake  = 1'b0;
		if (brownOutEvent) begin
			evSet   = bitMask(`BIT_BOR);
			evClr   = bitMask(`BIT_POR);
			evReset = 1'b1;
		end else if (pinFall) begin
			evReset = 1'b1;
			evSet   = bitMask(`BIT_EXTERNAL_RESET_FLAG);
			case (state_reg)
				ST_SLEEP: begin
					evSet = evSet | bitMask(`BIT_SLEEP);
					evClr = bitMask(`BIT_WATCHDOG_TIMEOUT_FLAG) | bitMask(`BIT_IDLE);
				end
				ST_IDLE: begin
					evSet = evSet | bitMask(`BIT_IDLE);
					evClr = bitMask(`BIT_WATCHDOG_TIMEOUT_FLAG) | bitMask(`BIT_SLEEP);
				end
				default: begin
					evClr = bitMask(`BIT_SWR) | bitMask(`BIT_WATCHDOG_TIMEOUT_FLAG)
						| bitMask(`BIT_IDLE) | bitMask(`BIT_SLEEP);
				end
			endcase
		end else if (wdtExpire && state_reg == ST_SLEEP) begin
			evSet  = bitMask(`BIT_WATCHDOG_TIMEOUT_FLAG) | bitMask(`BIT_SLEEP);
			evLoad = 1'b1;
			evPc   = currentPc + `PC_STEP;
			evWake = 1'b1;
		end else if (wdtExpire) begin
			evReset = 1'b1;
			evSet   = bitMask(`BIT_WATCHDOG_TIMEOUT_FLAG);
			evClr   = bitMask(`BIT_EXTERNAL_RESET_FLAG) | bitMask(`BIT_SWR)
				| bitMask(`BIT_IDLE) | bitMask(`BIT_SLEEP);
		end else if (trapLockupEvent) begin
			evReset = 1'b1;
			evSet   = bitMask(`BIT_TRAP);
		end else if (illegalOpEvent) begin
			evReset = 1'b1;
			evSet   = bitMask(`BIT_IOP);
		end else if (softwareResetInstr && state_reg == ST_RUN) begin
			evReset = 1'b1;
			evSet   = bitMask(`BIT_SWR);
			evClr   = bitMask(`BIT_EXTERNAL_RESET_FLAG) | bitMask(`BIT_WATCHDOG_TIMEOUT_FLAG)
				| bitMask(`BIT_IDLE) | bitMask(`BIT_SLEEP);
		end else if (interruptWake && state_reg != ST_RUN) begin
			evLoad = 1'b1;
			evPc   = interruptVector;
			evWake = 1'b1;
			if (state_reg == ST_SLEEP) begin
				evSet = bitMask(`BIT_SLEEP);
			end else begin
				evSet = bitMask(`BIT_IDLE);
			end
		end else if (clockFailEvent) begin
			evLoad = 1'b1;
			evPc   = `VEC_CLKFAIL;
		end
		if (evReset) begin
			evLoad = 1'b1;
			evPc   = `VEC_RESET;
		end
	end

	// -----------------------------------------------------------------
	// control register next value
	// -----------------------------------------------------------------
	always @* begin
		ctrlBase = ctrl_reg;
		if (regWrite && regAddr == `OFF_CTRL) begin
			// software may write every flag; the reference bit stays hardware-owned
			ctrlBase = (regWdata & `CTRL_WMASK) | (ctrl_reg & ~`CTRL_WMASK);
		end
		ctrl_next = setClr(ctrlBase, evSet, evClr);
	end

	// -----------------------------------------------------------------
	// power state
	// -----------------------------------------------------------------
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (powerSaveInstr && !evReset && !evLoad) begin
					if (powerSaveParam[0] == `PSAV_IDLE) begin
						state_next = ST_IDLE;
					end else begin
						state_next = ST_SLEEP;
					end
				end
			end
			ST_SLEEP, ST_IDLE: begin
				if (evWake) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
		if (evReset) begin
			state_next = ST_RUN;
		end
	end

	// -----------------------------------------------------------------
	// watchdog counter
	// -----------------------------------------------------------------
	always @* begin
		wdtCount_next = wdtCount_reg;
		if (evReset || evWake || clearWatchdogInstr || !wdtEnabled
			|| (powerSaveInstr && state_reg == ST_RUN)) begin
			wdtCount_next = {WDT_WIDTH{1'b0}};
		end else if (rcTick) begin
			if (wdtCount_reg == WDT_TIMEOUT) begin
				wdtCount_next = {WDT_WIDTH{1'b0}};
			end else begin
				wdtCount_next = wdtCount_reg + 1'b1;
			end
		end
	end

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	always @(posedge clk) begin
		if (reset) begin
			ctrl_reg        <= `CTRL_POR_VAL;
			cfgEnable_reg   <= `CFG_ERASED;
			state_reg       <= ST_RUN;
			wdtCount_reg    <= {WDT_WIDTH{1'b0}};
			rcSync1_reg     <= 1'b0;
			rcSync2_reg     <= 1'b0;
			rcSync3_reg     <= 1'b0;
			pinPrev_reg     <= 1'b1;
			refStable_reg   <= 1'b0;
			coreReset       <= 1'b1;
			restartLoad     <= 1'b1;
			restartPc       <= `VEC_RESET;
			powerState      <= ST_RUN;
			watchdogTimeout <= 1'b0;
			lowVoltageEvent <= 1'b0;
			regRdata        <= `ZERO16;
		end else begin
			ctrl_reg        <= ctrl_next;
			if (regWrite && regAddr == `OFF_CFG) begin
				cfgEnable_reg <= regWdata[0];
			end
			state_reg       <= state_next;
			wdtCount_reg    <= wdtCount_next;
			rcSync1_reg     <= wdtRcClk;
			rcSync2_reg     <= rcSync1_reg;
			rcSync3_reg     <= rcSync2_reg;
			pinPrev_reg     <= masterResetPinN;
			refStable_reg   <= referenceStableIn;
			coreReset       <= evReset;
			restartLoad     <= evLoad;
			if (evLoad) begin
				restartPc <= evPc;
			end
			powerState      <= state_next;
			watchdogTimeout <= wdtExpire;
			lowVoltageEvent <= ctrl_reg[`BIT_LOW_VOLTAGE_DETECT_ENABLE] & supplyBelowLevel;
			regRdata        <= `ZERO16;
			if (regRead) begin
				case (regAddr)
					`OFF_CTRL: begin
						regRdata             <= ctrl_reg;
						regRdata[`BIT_REFST] <= refStable_reg;
					end
					`OFF_STAT: begin
						regRdata <= {11'h0, state_reg, wdtEnabled, rcTick, cfgEnable_reg};
					end
					`OFF_CFG: begin
						regRdata <= {15'h0, cfgEnable_reg};
					end
					default: begin
						regRdata <= `ZERO16;
					end
				endcase
			end
		end
	end

	// -----------------------------------------------------------------
	// low-voltage detector controls
	// -----------------------------------------------------------------
	assign lowVoltageLevel  = ctrl_reg[`LOW_VOLTAGE_LEVEL_HI:`LOW_VOLTAGE_LEVEL_LO];
	assign lowVoltageEnable = ctrl_reg[`BIT_LOW_VOLTAGE_DETECT_ENABLE];

endmodule

// ---- bench/reset_cause_chk.sv ----
// checker for the reset-cause block, bound to its ports
`timescale 1ns/1ns
module reset_cause_chk (
	// clock and reset
	input wire        clk,
	input wire        reset,
	// register port
	input wire [7:0]  regAddr,
	input wire [15:0] regWdata,
	input wire        regWrite,
	input wire        regRead,
	input wire [15:0] regRdata,
	// events and pin
	input wire        brownOutEvent,
	input wire        softwareResetInstr,
	input wire        trapLockupEvent,
	input wire        illegalOpEvent,
	input wire        clockFailEvent,
	input wire        masterResetPinN,
	input wire        powerSaveInstr,
	input wire [7:0]  powerSaveParam,
	input wire        interruptWake,
	input wire [23:0] interruptVector,
	input wire        supplyBelowLevel,
	// outputs of the block
	input wire        coreReset,
	input wire        restartLoad,
	input wire [23:0] restartPc,
	input wire [1:0]  powerState,
	input wire        watchdogTimeout,
	input wire [3:0]  lowVoltageLevel,
	input wire        lowVoltageEnable,
	input wire        lowVoltageEvent
);
	// higher-priority events absent, so the lower one must be taken
	wire hiQuiet = !(brownOutEvent | trapLockupEvent | illegalOpEvent);
	wire quiet   = hiQuiet & !softwareResetInstr & !interruptWake;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	AST_POR_RESTART: assert property ($fell(reset) |-> coreReset && restartLoad && restartPc == 24'h000000 && powerState == 2'h0) else $error("power-on restart wrong");
	AST_RDATA_IDLE: assert property (!regRead |=> regRdata == 16'h0000) else $error("read data outside read slot");
	AST_PIN_RESET: assert property ($fell(masterResetPinN) && !brownOutEvent |=> coreReset && restartPc == 24'h000000 && powerState == 2'h0) else $error("pin reset not taken");
	AST_SW_RESET: assert property (softwareResetInstr && powerState == 2'h0 |=> coreReset && restartPc == 24'h000000) else $error("software reset not taken");
	AST_WDT_RESET: assert property (watchdogTimeout && $past(powerState) != 2'h1 |-> coreReset && restartPc == 24'h000000) else $error("watchdog reset wrong");
	AST_WDT_WAKE: assert property (watchdogTimeout && $past(powerState) == 2'h1 |-> !coreReset && restartLoad && powerState == 2'h0) else $error("watchdog wake wrong");
	AST_INT_WAKE: assert property (interruptWake && powerState != 2'h0 && hiQuiet && !$fell(masterResetPinN) |=> watchdogTimeout || (restartLoad && !coreReset && restartPc == $past(interruptVector))) else $error("interrupt wake wrong");
	AST_CLK_FAIL: assert property (clockFailEvent && quiet && !$fell(masterResetPinN) |=> watchdogTimeout || (restartLoad && !coreReset && restartPc == 24'h000004)) else $error("clock fail vector wrong");
	AST_LEVEL_FIELD: assert property (regWrite && regAddr == 8'h00 |=> lowVoltageLevel == $past(regWdata[11:8]) && lowVoltageEnable == $past(regWdata[12])) else $error("level or enable not written");
	AST_LVD_GATE: assert property (1'b1 |=> lowVoltageEvent == $past(lowVoltageEnable && supplyBelowLevel)) else $error("low-voltage event not gated");
	AST_POWER_SAVE: assert property (powerSaveInstr && powerState == 2'h0 && quiet && !clockFailEvent && !$fell(masterResetPinN) |=> watchdogTimeout || powerState == ($past(powerSaveParam[0]) ? 2'h2 : 2'h1)) else $error("power-save state wrong");
	cover property (watchdogTimeout);
	cover property (interruptWake && powerState != 2'h0);
	cover property ($fell(masterResetPinN) && powerState != 2'h0);
endmodule
bind reset_cause_watchdog_lvd_ctrl reset_cause_chk i_reset_cause_chk (.*);

// ---- bench/core_pin_model.sv ----
// model of the master reset pin and the on-chip RC oscillator
`timescale 1ns/1ns
module core_pin_model #(
	parameter RC_HALF = 337
) (
	// main clock
	input  wire  clk,
	// pin and oscillator
	output logic wdtRcClk,
	output logic masterResetPinN
);
	logic [1:0] lowCnt = 2'h0;
	initial wdtRcClk = 1'b0;
	initial masterResetPinN = 1'b1;
	// free running and unrelated in phase to clk, kept slower than clk/2
	always #(RC_HALF) wdtRcClk = ~wdtRcClk;
	// pull-up brings the pin back high after three cycles low
	task press;
		masterResetPinN <= 1'b0;
		lowCnt <= 2'h3;
	endtask
	always @(posedge clk) begin
		if (lowCnt != 2'h0) begin
			lowCnt <= lowCnt - 2'h1;
			if (lowCnt == 2'h1) masterResetPinN <= 1'b1;
		end
	end
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the reset-cause block
`timescale 1ns/1ns
module testbench;
	logic        clk = 0, reset = 1, regWrite = 0, regRead = 0, refSt, below = 0, seen;
	logic [7:0]  regAddr = 8'h00, psParam = 8'h00, evBus = 8'h00;
	logic [15:0] regWdata = 16'h0000, expCtrl, regRdata;
	logic [23:0] pc0, vec, restartPc;
	logic [31:0] rnd;
	logic [15:0] setT [0:5] = '{16'h0002, 16'h0040, 16'h8000, 16'h4000, 16'h0000, 16'h0080};
	logic [15:0] clrT [0:5] = '{16'h0001, 16'h009c, 16'h0000, 16'h0000, 16'h0000, 16'h005c};
	logic        coreReset, restartLoad, watchdogTimeout, wdtRcClk, masterResetPinN;
	logic        lvEn, lvEvent, belowPrev;
	logic [3:0]  lvLevel;
	logic [1:0]  powerState;
	integer      seed, i, k, failCount = 0, checks = 0;
	always #25 clk = ~clk;
	always @(posedge clk) below <= ^($random(seed));
	// comparator level as the block saw it at the last edge
	always @(posedge clk) belowPrev <= below;
	core_pin_model i_core_pin_model (.clk(clk), .wdtRcClk(wdtRcClk),
		.masterResetPinN(masterResetPinN));
	reset_cause_watchdog_lvd_ctrl #(.WDT_WIDTH(16), .WDT_TIMEOUT(16'h0004))
	i_reset_cause_watchdog_lvd_ctrl (.clk(clk), .reset(reset), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.brownOutEvent(evBus[0]), .softwareResetInstr(evBus[1]), .trapLockupEvent(evBus[2]),
		.illegalOpEvent(evBus[3]), .clockFailEvent(evBus[4]), .interruptWake(evBus[5]),
		.powerSaveInstr(evBus[6]), .clearWatchdogInstr(evBus[7]), .powerSaveParam(psParam),
		.masterResetPinN(masterResetPinN), .interruptVector(vec), .currentPc(pc0),
		.wdtRcClk(wdtRcClk), .referenceStableIn(refSt), .supplyBelowLevel(below),
		.coreReset(coreReset), .restartLoad(restartLoad), .restartPc(restartPc),
		.powerState(powerState), .watchdogTimeout(watchdogTimeout), .lowVoltageLevel(lvLevel),
		.lowVoltageEnable(lvEn), .lowVoltageEvent(lvEvent));
	task results;
		if (failCount == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string n, input logic [23:0] e, input logic [23:0] g);
		checks++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", n, e, g);
			failCount++;
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		regWrite <= w;
		regRead <= !w;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
		regRead <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0000);
		chk("regRdata", {8'h00, e}, {8'h00, regRdata});
	endtask
	task rdc;
		rd(8'h00, expCtrl | {2'b00, refSt, 13'h0000});
		chk("lowVoltageLevel", {20'h0, expCtrl[11:8]}, {20'h0, lvLevel});
		chk("lowVoltageEnable", {23'h0, expCtrl[12]}, {23'h0, lvEn});
		chk("lowVoltageEvent", {23'h0, expCtrl[12] & belowPrev}, {23'h0, lvEvent});
	endtask
	task scramble;
		rnd = $random(seed);
		refSt <= rnd[16];
		expCtrl = rnd[15:0] & 16'hdfdf;
		bus(1'b1, 8'h00, expCtrl);
	endtask
	task pulse(input integer b);
		@(posedge clk);
		if (b == 8) i_core_pin_model.press();
		else evBus[b] <= 1'b1;
		@(posedge clk);
		evBus <= 8'h00;
		#1;
	endtask
	task ev(input integer b, input logic [15:0] s, input logic [15:0] c,
		input logic [23:0] pc, input logic r);
		pulse(b);
		chk("coreReset", {23'h0, r}, {23'h0, coreReset});
		chk("restartLoad", 24'h000001, {23'h0, restartLoad});
		chk("restartPc", pc, restartPc);
		chk("powerState", 24'h000000, {22'h0, powerState});
		expCtrl = (expCtrl & ~c) | s;
		rdc();
	endtask
	task ps(input logic p);
		psParam <= {rnd[7:1], p};
		pulse(6);
		chk("powerState", p ? 24'h000002 : 24'h000001, {22'h0, powerState});
	endtask
	task waitLoad(input integer n);
		seen = 1'b0;
		repeat (n) begin
			@(posedge clk);
			#1;
			if (restartLoad === 1'b1) begin
				seen = 1'b1;
				break;
			end
		end
	endtask
	initial begin
		#500000;
		failCount++;
		results();
	end
	initial begin
		seed = 12688;
		rnd = $random(seed);
		refSt = rnd[0];
		pc0 = {1'b0, rnd[23:2], 1'b0};
		vec = {rnd[31:10], 2'b00};
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		expCtrl = 16'h0003;
		rdc();
		rd(8'h08, 16'h0001);
		bus(1'b1, 8'h08, 16'h0000);
		// tick bit masked: it follows the free-running oscillator
		bus(1'b0, 8'h04, 16'h0000);
		chk("status", 24'h000000, {8'h00, regRdata & 16'hfffd});
		bus(1'b1, 8'h10, 16'hffff);
		rd(8'h10, 16'h0000);
		for (i = 0; i < 4; i++) begin
			scramble();
			rdc();
		end
		for (k = 0; k < 6; k++) begin
			scramble();
			ev(k == 5 ? 8 : k, setT[k], clrT[k], k == 4 ? 24'h000004 : 24'h000000, k != 4);
		end
		ps(1'b0);
		ev(8, 16'h0088, 16'h0014, 24'h000000, 1'b1);
		ps(1'b1);
		ev(8, 16'h0084, 16'h0018, 24'h000000, 1'b1);
		ps(1'b0);
		pulse(1);
		chk("swInSleep", 24'h000001, {22'h0, powerState});
		chk("swInSleepRst", 24'h000000, {23'h0, coreReset});
		ev(5, 16'h0008, 16'h0000, vec, 1'b0);
		pulse(5);
		chk("intInRun", 24'h000000, {23'h0, restartLoad});
		bus(1'b1, 8'h08, 16'h0001);
		waitLoad(400);
		chk("wdReset", 24'h000001, {23'h0, coreReset & watchdogTimeout});
		chk("restartPc", 24'h000000, restartPc);
		expCtrl = (expCtrl & 16'hff33) | 16'h0010;
		rdc();
		ps(1'b0);
		bus(1'b0, 8'h04, 16'h0000);
		chk("status", 24'h00000d, {8'h00, regRdata & 16'hfffd});
		waitLoad(400);
		chk("wdWake", pc0 + 24'h000002, restartPc);
		chk("powerState", 24'h000000, {22'h0, powerState});
		expCtrl = expCtrl | 16'h0018;
		rdc();
		for (i = 0; i < 20; i++) begin
			pulse(7);
			waitLoad(15);
			chk("wdCleared", 24'h000000, {23'h0, seen});
		end
		bus(1'b1, 8'h08, 16'h0000);
		expCtrl = expCtrl | 16'h0020;
		bus(1'b1, 8'h00, expCtrl);
		waitLoad(400);
		chk("swWatchdog", 24'h000001, {23'h0, seen});
		expCtrl = (expCtrl & 16'hff13) | 16'h0010;
		bus(1'b1, 8'h00, expCtrl);
		waitLoad(300);
		chk("wdOff", 24'h000000, {23'h0, seen});
		rdc();
		// second power-on in mid-run must put every flag back to its power-on value 0003
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		expCtrl = 16'h0003;
		rdc();
		rd(8'h08, 16'h0001);
		results();
	end
endmodule
